//--- shared/ctad_pkg.sv
package ctad_pkg;

  // ----------------------------------------
  // Operation, size and state encodings
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_MOV_RR = 5'h01,
    OP_MOV_IMM = 5'h02,
    OP_MOV_LOAD = 5'h03,
    OP_MOV_STORE = 5'h04,
    OP_PERIPHERAL_MOVE_FROM = 5'h05,
    OP_PERIPHERAL_MOVE_TO = 5'h06,
    OP_POP = 5'h07,
    OP_PUSH = 5'h08,
    OP_MULTI_REGISTER_LOAD = 5'h09,
    OP_MULTI_REGISTER_STORE = 5'h0a,
    OP_ADD = 5'h0b,
    OP_SUB = 5'h0c,
    OP_ADD_WITH_CARRY = 5'h0d,
    OP_SUBTRACT_WITH_CARRY = 5'h0e,
    OP_INC = 5'h0f,
    OP_DEC = 5'h10,
    OP_FIXED_STEP_ADD = 5'h11,
    OP_FIXED_STEP_SUBTRACT = 5'h12,
    OP_DECIMAL_ADJUST_ADD = 5'h13,
    OP_DECIMAL_ADJUST_SUBTRACT = 5'h14,
    OP_UNSIGNED_MULTIPLY = 5'h15,
    OP_SIGNED_MULTIPLY = 5'h16,
    OP_UNSIGNED_DIVIDE = 5'h17
  } ctad_op_t;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} ctad_size_t;

  // Gray along idle -> issue -> wait
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ISSUE = 2'h1, ST_WAIT = 2'h3} ctad_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    ctad_op_t op;
    ctad_size_t size;
    logic [3:0] rd;
    logic [3:0] rs;
    logic use_imm;
    logic [31:0] imm;
    logic [2:0] step;
    logic [2:0] count;
  } ctad_cmd_t;

  typedef struct packed {logic h; logic n; logic z; logic v; logic c;} ctad_flags_t;

  typedef struct packed {
    logic valid;
    logic we;
    ctad_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ctad_mem_t;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [2:0] LIST_MIN = 3'h2;
  localparam logic [2:0] LIST_MAX = 3'h4;
  localparam logic [3:0] LIST_END = 4'h7;
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h4;
  localparam logic [4:0] BYTE_SHIFT = 5'h18;
  localparam logic [4:0] WORD_SHIFT = 5'h10;
  localparam logic [4:0] LONG_SHIFT = 5'h00;
  localparam int HALF_CARRY_BIT = 28;
  localparam logic [7:0] BCD_MAX = 8'h99;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [4:0] FLAGS_RST = 5'h00;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Left shift that puts the operand's sign bit at bit 31
  function automatic logic [4:0] size_shift(input ctad_size_t s);
    case (s)
      SZ_BYTE: size_shift = BYTE_SHIFT;
      SZ_WORD: size_shift = WORD_SHIFT;
      default: size_shift = LONG_SHIFT;
    endcase
  endfunction

endpackage

//--- hdl/ctad_alu.sv
module ctad_alu (
  input ctad_pkg::ctad_op_t op,
  input ctad_pkg::ctad_size_t size,
  input logic [31:0] a,
  input logic [31:0] b,
  input ctad_pkg::ctad_flags_t flags_i,
  output logic [31:0] res,
  output ctad_pkg::ctad_flags_t flags_o
);
  import ctad_pkg::*;

  // ----------------------------------------
  // Size-aligned adder and subtractor
  // ----------------------------------------
  // Operands sit at the top so carry, sign and overflow fall out at bits 32/31
  logic [4:0] sh;
  logic cin;
  logic [31:0] a_s;
  logic [31:0] b_s;
  logic [31:0] c_s;
  logic [32:0] sum;
  logic [32:0] dif;
  logic [31:0] hx_add;
  logic [31:0] hx_sub;
  assign sh = size_shift(size);
  assign cin = (op == OP_ADD_WITH_CARRY || op == OP_SUBTRACT_WITH_CARRY) ? flags_i.c : 1'b0;
  assign a_s = a << sh;
  assign b_s = b << sh;
  assign c_s = {31'h0, cin} << sh;
  assign sum = {1'b0, a_s} + {1'b0, b_s} + {1'b0, c_s};
  assign dif = {1'b0, a_s} - {1'b0, b_s} - {1'b0, c_s};
  assign hx_add = a_s ^ b_s ^ sum[31:0];
  assign hx_sub = a_s ^ b_s ^ dif[31:0];

  // Decimal correction terms
  logic da_hi;
  logic da_lo;
  logic [7:0] da_add;
  logic [7:0] da_sub;
  assign da_hi = flags_i.c | (a[7:0] > BCD_MAX);
  assign da_lo = flags_i.h | (a[3:0] > DIGIT_MAX);
  assign da_add = a[7:0] + (da_hi ? BCD_HI_FIX : 8'h00) + (da_lo ? BCD_LO_FIX : 8'h00);
  assign da_sub = a[7:0] - (flags_i.c ? BCD_HI_FIX : 8'h00) - (flags_i.h ? BCD_LO_FIX : 8'h00);

  // Multiply and divide
  logic [15:0] pu_b;
  logic [31:0] pu_w;
  logic signed [15:0] ps_b;
  logic signed [31:0] ps_w;
  logic [15:0] dq_b;
  logic [15:0] dr_b;
  logic [31:0] dq_w;
  logic [31:0] dr_w;
  logic dz;
  // Operands widened first so the product keeps its upper half
  assign pu_b = {8'h00, a[7:0]} * {8'h00, b[7:0]};
  assign pu_w = {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
  assign ps_b = $signed({{8{a[7]}}, a[7:0]}) * $signed({{8{b[7]}}, b[7:0]});
  assign ps_w = $signed({{16{a[15]}}, a[15:0]}) * $signed({{16{b[15]}}, b[15:0]});
  assign dz = (size == SZ_BYTE) ? (b[7:0] == 8'h00) : (b[15:0] == 16'h0000);
  assign dq_b = dz ? 16'h0000 : a[15:0] / {8'h00, b[7:0]};
  assign dr_b = dz ? 16'h0000 : a[15:0] % {8'h00, b[7:0]};
  assign dq_w = dz ? 32'h0000_0000 : a / {16'h0000, b[15:0]};
  assign dr_w = dz ? 32'h0000_0000 : a % {16'h0000, b[15:0]};

  // ----------------------------------------
  // Result and flag selection
  // ----------------------------------------
  always_comb begin
    res = a;
    flags_o = flags_i;
    case (op)
      OP_MOV_RR, OP_MOV_IMM: begin
        res = b;
        flags_o.n = b_s[31];
        flags_o.z = (b_s == 32'h0000_0000);
        flags_o.v = 1'b0;
      end
      OP_ADD, OP_ADD_WITH_CARRY, OP_INC: begin
        res = sum[31:0] >> sh;
        flags_o.n = sum[31];
        flags_o.z = (sum[31:0] == 32'h0000_0000);
        flags_o.v = (a_s[31] == b_s[31]) && (sum[31] != a_s[31]);
        if (op != OP_INC) begin
          flags_o.h = hx_add[HALF_CARRY_BIT];
          flags_o.c = sum[32];
        end
        // Carry-chained ops only ever clear Z
        if (op == OP_ADD_WITH_CARRY) begin
          flags_o.z = flags_i.z & (sum[31:0] == 32'h0000_0000);
        end
      end
      OP_SUB, OP_SUBTRACT_WITH_CARRY, OP_DEC: begin
        res = dif[31:0] >> sh;
        flags_o.n = dif[31];
        flags_o.z = (dif[31:0] == 32'h0000_0000);
        flags_o.v = (a_s[31] != b_s[31]) && (dif[31] != a_s[31]);
        if (op != OP_DEC) begin
          flags_o.h = hx_sub[HALF_CARRY_BIT];
          flags_o.c = dif[32];
        end
        if (op == OP_SUBTRACT_WITH_CARRY) begin
          flags_o.z = flags_i.z & (dif[31:0] == 32'h0000_0000);
        end
      end
      OP_FIXED_STEP_ADD: res = a + b;
      OP_FIXED_STEP_SUBTRACT: res = a - b;
      OP_DECIMAL_ADJUST_ADD: begin
        res = {24'h00_0000, da_add};
        flags_o.n = da_add[7];
        flags_o.z = (da_add == 8'h00);
        flags_o.c = da_hi;
      end
      OP_DECIMAL_ADJUST_SUBTRACT: begin
        res = {24'h00_0000, da_sub};
        flags_o.n = da_sub[7];
        flags_o.z = (da_sub == 8'h00);
      end
      OP_UNSIGNED_MULTIPLY: begin
        res = (size == SZ_BYTE) ? {16'h0000, pu_b} : pu_w;
      end
      OP_SIGNED_MULTIPLY: begin
        res = (size == SZ_BYTE) ? {16'h0000, ps_b} : ps_w;
        flags_o.n = (size == SZ_BYTE) ? ps_b[15] : ps_w[31];
        flags_o.z = (size == SZ_BYTE) ? (ps_b == 16'sh0000) : (ps_w == 32'sh0000_0000);
      end
      OP_UNSIGNED_DIVIDE: begin
        // Divide by zero leaves the dividend in place
        if (!dz) begin
          res = (size == SZ_BYTE) ? {16'h0000, dr_b[7:0], dq_b[7:0]} : {dr_w[15:0], dq_w[15:0]};
        end
        flags_o.n = (size == SZ_BYTE) ? b[7] : b[15];
        flags_o.z = dz;
      end
      default: res = a;
    endcase
  end

endmodule

//--- hdl/ctad_datapath.sv
module ctad_datapath (
  input logic clk,
  input logic rst_n,
  input logic cmd_valid,
  input ctad_pkg::ctad_cmd_t cmd,
  output logic cmd_ready,
  output logic done,
  output logic err,
  input logic flags_load,
  input ctad_pkg::ctad_flags_t flags_in,
  output ctad_pkg::ctad_flags_t flags,
  output ctad_pkg::ctad_mem_t mem,
  input logic mem_ack,
  input logic [31:0] mem_rdata,
  input logic [2:0] dbg_sel,
  output logic [31:0] dbg_data
);
  import ctad_pkg::*;

  // ----------------------------------------
  // Field access helpers
  // ----------------------------------------
  // Byte sel<8 is the high byte, word sel>=8 the upper half
  function automatic logic [31:0] ext_field(input logic [31:0] v, input ctad_size_t s, input logic [3:0] sel);
    case (s)
      SZ_BYTE: ext_field = {24'h00_0000, sel[3] ? v[7:0] : v[15:8]};
      SZ_WORD: ext_field = {16'h0000, sel[3] ? v[31:16] : v[15:0]};
      default: ext_field = v;
    endcase
  endfunction

  function automatic logic [31:0] ins_field(input logic [31:0] old, input ctad_size_t s, input logic [3:0] sel,
                                            input logic [31:0] val);
    ins_field = old;
    case (s)
      SZ_BYTE: if (sel[3]) ins_field[7:0] = val[7:0]; else ins_field[15:8] = val[7:0];
      SZ_WORD: if (sel[3]) ins_field[31:16] = val[15:0]; else ins_field[15:0] = val[15:0];
      default: ins_field = val;
    endcase
  endfunction

  function automatic logic [31:0] bytes_of(input ctad_size_t s);
    case (s)
      SZ_BYTE: bytes_of = 32'h0000_0001;
      SZ_WORD: bytes_of = 32'h0000_0002;
      default: bytes_of = 32'h0000_0004;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] gr_r [8];
  ctad_state_t st_r;
  ctad_state_t st_nxt;
  ctad_cmd_t q_r;
  logic [2:0] beat_r;
  logic ready_r;
  logic done_r;
  logic err_r;
  ctad_flags_t flags_r;
  ctad_mem_t mem_r;
  ctad_mem_t mem_nxt;
  logic [31:0] dbg_r;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic take;
  logic is_mem;
  logic is_wide;
  logic is_step;
  logic is_list;
  logic bad;
  ctad_size_t eff_sz;
  ctad_size_t wide_sz;
  ctad_size_t wr_sz;
  logic [3:0] dst_sel;
  logic [31:0] a_op;
  logic [31:0] b_op;
  logic [31:0] sp;
  assign take = cmd_valid & ready_r;
  assign sp = gr_r[SP_IDX];
  assign is_mem = cmd.op inside {OP_MOV_LOAD, OP_MOV_STORE, OP_POP, OP_PUSH, OP_MULTI_REGISTER_LOAD,
                                 OP_MULTI_REGISTER_STORE};
  assign is_wide = cmd.op inside {OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY, OP_UNSIGNED_DIVIDE};
  assign is_step = cmd.op inside {OP_INC, OP_DEC, OP_FIXED_STEP_ADD, OP_FIXED_STEP_SUBTRACT};
  assign is_list = cmd.op inside {OP_MULTI_REGISTER_LOAD, OP_MULTI_REGISTER_STORE};
  // Unsupported forms complete at once with err and change nothing
  assign bad = (cmd.op inside {OP_PERIPHERAL_MOVE_FROM, OP_PERIPHERAL_MOVE_TO})
             | (cmd.op == OP_SUB && cmd.use_imm && cmd.size == SZ_BYTE)
             | ((cmd.op inside {OP_INC, OP_DEC}) && !(cmd.step == STEP_1 ||
                (cmd.step == STEP_2 && cmd.size != SZ_BYTE)))
             | ((cmd.op inside {OP_FIXED_STEP_ADD, OP_FIXED_STEP_SUBTRACT}) &&
                !(cmd.step inside {STEP_1, STEP_2, STEP_4}))
             | ((cmd.op inside {OP_POP, OP_PUSH}) && cmd.size == SZ_BYTE)
             | (is_list && (cmd.count < LIST_MIN || cmd.count > LIST_MAX ||
                ({1'b0, cmd.rd[2:0]} + {1'b0, cmd.count}) > LIST_END))
             | (is_wide && cmd.size == SZ_LONG)
             | ((cmd.op inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY, OP_DECIMAL_ADJUST_ADD,
                 OP_DECIMAL_ADJUST_SUBTRACT}) && cmd.size != SZ_BYTE);
  // Fixed-step always works on the whole 32-bit register
  assign eff_sz = (cmd.op inside {OP_FIXED_STEP_ADD, OP_FIXED_STEP_SUBTRACT}) ? SZ_LONG : cmd.size;
  assign wide_sz = (cmd.size == SZ_BYTE) ? SZ_WORD : SZ_LONG;
  assign wr_sz = is_wide ? wide_sz : eff_sz;
  assign dst_sel = is_wide ? {1'b0, cmd.rd[2:0]} : cmd.rd;
  // Register operands picked by size and half/byte select
  assign a_op = ext_field(gr_r[cmd.rd[2:0]], wr_sz, dst_sel);
  assign b_op = cmd.use_imm ? cmd.imm : is_step ? {29'h0, cmd.step} :
                ext_field(gr_r[cmd.rs[2:0]], cmd.size, cmd.rs);

  // ----------------------------------------
  // Memory sequence decode
  // ----------------------------------------
  logic q_list;
  logic q_ldm;
  logic q_load;
  logic q_predec;
  logic q_postinc;
  logic last;
  logic [2:0] list_idx;
  logic [31:0] q_bytes;
  logic [31:0] raw_addr;
  logic [31:0] st_data;
  assign q_ldm = (q_r.op == OP_MULTI_REGISTER_LOAD);
  assign q_list = q_ldm | (q_r.op == OP_MULTI_REGISTER_STORE);
  assign q_load = q_r.op inside {OP_MOV_LOAD, OP_POP, OP_MULTI_REGISTER_LOAD};
  assign q_predec = q_r.op inside {OP_PUSH, OP_MULTI_REGISTER_STORE};
  assign q_postinc = q_r.op inside {OP_POP, OP_MULTI_REGISTER_LOAD};
  assign q_bytes = bytes_of(q_r.size);
  assign last = !q_list || (beat_r == q_r.count - 3'h1);
  // Loads walk the list downward so they undo a store's order
  assign list_idx = q_ldm ? q_r.rd[2:0] + q_r.count - 3'h1 - beat_r : q_r.rd[2:0] + beat_r;
  assign raw_addr = q_predec ? sp - q_bytes :
                    q_postinc ? sp :
                    (q_r.op == OP_MOV_LOAD) ? gr_r[q_r.rs[2:0]] : gr_r[q_r.rd[2:0]];
  assign st_data = q_list ? gr_r[list_idx] : ext_field(gr_r[q_r.rs[2:0]], q_r.size, q_r.rs);

  // ----------------------------------------
  // Arithmetic unit and its input steering
  // ----------------------------------------
  ctad_op_t alu_op;
  ctad_size_t alu_sz;
  logic [31:0] alu_b;
  logic [31:0] alu_res;
  ctad_flags_t alu_fl;
  assign alu_op = (st_r == ST_IDLE) ? cmd.op : OP_MOV_RR;
  assign alu_sz = (st_r == ST_IDLE) ? (is_wide ? cmd.size : eff_sz) : q_r.size;
  assign alu_b = (st_r == ST_IDLE) ? b_op : (st_r == ST_ISSUE) ? st_data : mem_rdata;

  ctad_alu u_alu (
    .op(alu_op),
    .size(alu_sz),
    .a(a_op),
    .b(alu_b),
    .flags_i(flags_r),
    .res(alu_res),
    .flags_o(alu_fl)
  );

  // ----------------------------------------
  // Register file write steering
  // ----------------------------------------
  logic got;
  logic reg_wr;
  logic ld_wr;
  logic sp_wr;
  logic fl_wr;
  logic [2:0] wr_idx;
  logic [31:0] wr_val;
  logic [31:0] sp_val;
  assign got = (st_r == ST_WAIT) && mem_ack;
  assign reg_wr = take && !is_mem && !bad && cmd.op != OP_NOP;
  assign ld_wr = got && q_load;
  assign wr_idx = reg_wr ? cmd.rd[2:0] : q_ldm ? list_idx : q_r.rd[2:0];
  assign wr_val = reg_wr ? ins_field(gr_r[cmd.rd[2:0]], wr_sz, dst_sel, alu_res) :
                  q_ldm ? mem_rdata : ins_field(gr_r[q_r.rd[2:0]], q_r.size, q_r.rd, alu_res);
  assign sp_wr = (st_r == ST_ISSUE && q_predec) || (got && q_postinc);
  assign sp_val = q_predec ? sp - q_bytes : sp + q_bytes;
  // Flags follow every ALU op; list transfers leave them alone
  assign fl_wr = reg_wr || (st_r == ST_ISSUE && (q_r.op inside {OP_MOV_STORE, OP_PUSH})) ||
                 (got && (q_r.op inside {OP_MOV_LOAD, OP_POP}));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (take && is_mem && !bad) st_nxt = ST_ISSUE;
      ST_ISSUE: st_nxt = ST_WAIT;
      ST_WAIT: if (mem_ack) st_nxt = last ? ST_IDLE : ST_ISSUE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Request held until acknowledged; word/long address made even
  always_comb begin
    mem_nxt = mem_r;
    if (st_r == ST_ISSUE) begin
      mem_nxt.valid = 1'b1;
      mem_nxt.we = !q_load;
      mem_nxt.size = q_r.size;
      mem_nxt.addr = (q_r.size == SZ_BYTE) ? raw_addr : {raw_addr[31:1], 1'b0};
      mem_nxt.wdata = st_data;
    end else if (got) begin
      mem_nxt.valid = 1'b0;
    end
  end

  // Control flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      q_r <= '0;
      beat_r <= 3'h0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      mem_r <= '0;
    end else begin
      st_r <= st_nxt;
      ready_r <= (st_nxt == ST_IDLE);
      done_r <= (take && !(is_mem && !bad)) || (got && last);
      err_r <= take && bad;
      mem_r <= mem_nxt;
      if (take) q_r <= cmd;
      if (take) beat_r <= 3'h0;
      else if (got) beat_r <= beat_r + 3'h1;
    end
  end

  // Register file; a load into the same register wins over SP
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) gr_r[i] <= REG_RST;
      dbg_r <= REG_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sp_wr && i == int'(SP_IDX)) gr_r[i] <= sp_val;
        if ((reg_wr || ld_wr) && i == int'(wr_idx)) gr_r[i] <= wr_val;
      end
      dbg_r <= gr_r[dbg_sel];
    end
  end

  // Condition flags; an instruction beats an external load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flags_r <= FLAGS_RST;
    else if (fl_wr) flags_r <= alu_fl;
    else if (flags_load) flags_r <= flags_in;
  end

  assign cmd_ready = ready_r;
  assign done = done_r;
  assign err = err_r;
  assign flags = flags_r;
  assign mem = mem_r;
  assign dbg_data = dbg_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [32:0] chk_sum;
  assign chk_sum = {1'b0, gr_r[cmd.rd[2:0]]} + {1'b0, cmd.imm};

  // Reference values rebuilt from the operands, not from the unit
  logic [31:0] chk_rd;
  logic [7:0] chk_adc;
  logic [15:0] chk_prod;
  assign chk_rd = gr_r[cmd.rd[2:0]];
  assign chk_adc = a_op[7:0] + b_op[7:0] + {7'h00, flags_r.c};
  assign chk_prod = {8'h00, a_op[7:0]} * {8'h00, b_op[7:0]};

  mem_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_mem && !bad |=> !ready_r && st_r == ST_ISSUE ##1 mem_r.valid)
    else $error("memory op not issued after accept");
  pmove_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && cmd.op inside {OP_PERIPHERAL_MOVE_FROM, OP_PERIPHERAL_MOVE_TO} |=> err_r && done_r && ready_r)
    else $error("peripheral move not refused");
  pop_sp_a: assert property (@(posedge clk) disable iff (!rst_n)
    got && q_r.op == OP_POP && q_r.size == SZ_LONG && q_r.rd[2:0] != SP_IDX |=> sp == $past(sp) + 32'h0000_0004)
    else $error("pop did not advance stack pointer by four");
  push_sp_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == ST_ISSUE && q_r.op == OP_PUSH |=>
      sp == $past(sp) - $past(q_bytes) && mem_r.addr == {sp[31:1], 1'b0} && mem_r.we)
    else $error("push did not predecrement before write");
  list_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    got && q_ldm |=> sp == $past(sp) + 32'h0000_0004)
    else $error("list load beat did not pop a longword");
  list_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && cmd.op == OP_MULTI_REGISTER_STORE && !bad |=> ##1 sp == $past(sp, 2) - 32'h0000_0004)
    else $error("list store first beat did not push");
  even_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    mem_r.valid && mem_r.size != SZ_BYTE |-> !mem_r.addr[0])
    else $error("odd word or longword address on bus");
  zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && cmd.op == OP_MOV_IMM && cmd.size == SZ_LONG |=> flags_r.z == ($past(cmd.imm) == 32'h0000_0000))
    else $error("zero flag wrong after immediate move");
  add_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && cmd.op == OP_ADD && cmd.use_imm && cmd.size == SZ_LONG |=> flags_r.c == $past(chk_sum[32]))
    else $error("carry flag wrong after longword add");
  byte_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    take && cmd.op == OP_INC && cmd.size == SZ_BYTE && cmd.step == STEP_2 |=>
      err_r && gr_r[q_r.rd[2:0]] == $past(chk_rd))
    else $error("byte increment by two was accepted");
  // Carry folded into the byte sum
  carry_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && cmd.op == OP_ADD_WITH_CARRY |=>
      ext_field(gr_r[q_r.rd[2:0]], SZ_BYTE, q_r.rd) == {24'h00_0000, $past(chk_adc)})
    else $error("byte add with carry result wrong");
  byte_product_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && cmd.op == OP_UNSIGNED_MULTIPLY && cmd.size == SZ_BYTE |=> gr_r[q_r.rd[2:0]][15:0] == $past(chk_prod))
    else $error("byte unsigned product wrong");
  // Quotient and remainder must rebuild the dividend
  byte_divide_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && cmd.op == OP_UNSIGNED_DIVIDE && cmd.size == SZ_BYTE && b_op[7:0] != 8'h00 |=>
      {8'h00, gr_r[q_r.rd[2:0]][7:0]} * $past({8'h00, b_op[7:0]}) +
      {8'h00, gr_r[q_r.rd[2:0]][15:8]} == $past(a_op[15:0]) && gr_r[q_r.rd[2:0]][15:8] < $past(b_op[7:0]))
    else $error("byte quotient and remainder do not rebuild dividend");
  mem_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    got && last |=> done_r && ready_r && !mem_r.valid)
    else $error("transfer end not reported");

  push_cov: cover property (@(posedge clk) disable iff (!rst_n) got && q_r.op == OP_PUSH);
  list_load_cov: cover property (@(posedge clk) disable iff (!rst_n) got && q_ldm && last);
  list_store_cov: cover property (@(posedge clk) disable iff (!rst_n) got && q_r.op == OP_MULTI_REGISTER_STORE && last);
  divide_cov: cover property (@(posedge clk) disable iff (!rst_n) reg_wr && cmd.op == OP_UNSIGNED_DIVIDE);
  daa_cov: cover property (@(posedge clk) disable iff (!rst_n) reg_wr && cmd.op == OP_DECIMAL_ADJUST_ADD);

endmodule

//--- sim/test_cpu_transfer_arith_datapath.sv
module test_cpu_transfer_arith_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  import ctad_pkg::*;
  logic clk, rst_n, cmd_valid, cmd_ready, done, err, flags_load, mem_ack, err_seen, m_we;
  ctad_cmd_t cmd;
  ctad_flags_t flags_in, flags;
  ctad_mem_t mem;
  logic [31:0] mem_rdata, dbg_data, m_addr, m_wdata;
  logic [2:0] dbg_sel;
  int beats, num_errors = 0, checks_done = 0;
  ctad_datapath ctad_datapath_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .err(err), .flags_load(flags_load), .flags_in(flags_in),
    .flags(flags), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dbg_sel(dbg_sel), .dbg_data(dbg_data));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Offer one command, serve memory beats, wait for done
  task automatic run(input ctad_op_t op, input ctad_size_t sz, input logic [3:0] rd, input logic [3:0] rs,
                     input logic ui, input logic [31:0] imm, input logic [2:0] st = 3'h1, input logic [2:0] cn = 3'h0);
    int n;
    beats = 0;
    err_seen = 1'b0;
    @(posedge clk);
    cmd <= '{op, sz, rd, rs, ui, imm, st, cn};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (done === 1'b1) begin
        err_seen = err;
        break;
      end
      if (mem.valid === 1'b1) begin
        m_addr = mem.addr;
        m_wdata = mem.wdata;
        m_we = mem.we;
        check(32'(cmd_ready), 32'h0);
        beats++;
        @(posedge clk);
        mem_ack <= 1'b1;
        @(posedge clk);
        mem_ack <= 1'b0;
      end
    end
    check(32'(n < 60), 32'h1);
  endtask
  task automatic reg_is(input logic [2:0] idx, input logic [31:0] exp);
    @(posedge clk);
    dbg_sel <= idx;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(dbg_data, exp);
  endtask
  task automatic t_move;
    run(OP_MOV_IMM, SZ_LONG, 4'h0, 4'h0, 1'b1, 32'h1234_5678);
    run(OP_MOV_IMM, SZ_BYTE, 4'h8, 4'h0, 1'b1, 32'h0000_00ab);
    reg_is(3'h0, 32'h1234_56ab);
    run(OP_MOV_RR, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0000_0000);
    reg_is(3'h2, 32'h1234_56ab);
    run(OP_PERIPHERAL_MOVE_TO, SZ_BYTE, 4'h1, 4'h0, 1'b0, 32'h0000_0000);
    check(32'(err_seen), 32'h1);
    $display("test move done");
  endtask
  task automatic t_arith;
    run(OP_ADD, SZ_LONG, 4'h2, 4'h0, 1'b1, 32'hedcb_a955);
    check(32'({flags.z, flags.c}), 32'h3);
    run(OP_SUB, SZ_BYTE, 4'ha, 4'h0, 1'b1, 32'h0000_0001);
    check(32'(err_seen), 32'h1);
    run(OP_ADD_WITH_CARRY, SZ_BYTE, 4'ha, 4'h0, 1'b1, 32'h0000_0000);
    reg_is(3'h2, 32'h0000_0001);
    run(OP_INC, SZ_WORD, 4'h2, 4'h0, 1'b0, 32'h0000_0000, 3'h2);
    run(OP_FIXED_STEP_ADD, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0000_0000, 3'h4);
    reg_is(3'h2, 32'h0000_0007);
    run(OP_INC, SZ_BYTE, 4'ha, 4'h0, 1'b0, 32'h0000_0000, 3'h2);
    check(32'(err_seen), 32'h1);
    run(OP_DEC, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0000_0000, 3'h1);
    run(OP_FIXED_STEP_SUBTRACT, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0000_0000, 3'h2);
    reg_is(3'h2, 32'h0000_0004);
    run(OP_MOV_IMM, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h0000_0029);
    run(OP_ADD, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h0000_0018);
    run(OP_DECIMAL_ADJUST_ADD, SZ_BYTE, 4'h9, 4'h0, 1'b0, 32'h0000_0000);
    reg_is(3'h1, 32'h0000_0047);
    run(OP_SUBTRACT_WITH_CARRY, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h0000_0018);
    run(OP_DECIMAL_ADJUST_SUBTRACT, SZ_BYTE, 4'h9, 4'h0, 1'b0, 32'h0000_0000);
    reg_is(3'h1, 32'h0000_0029);
    $display("test arith done");
  endtask
  task automatic t_muldiv;
    run(OP_MOV_IMM, SZ_LONG, 4'h3, 4'h0, 1'b1, 32'h0000_00ff);
    run(OP_MOV_IMM, SZ_LONG, 4'h4, 4'h0, 1'b1, 32'h0000_0002);
    run(OP_SIGNED_MULTIPLY, SZ_BYTE, 4'hb, 4'hc, 1'b0, 32'h0000_0000);
    reg_is(3'h3, 32'h0000_fffe);
    run(OP_MOV_IMM, SZ_LONG, 4'h3, 4'h0, 1'b1, 32'h0000_00ff);
    run(OP_UNSIGNED_MULTIPLY, SZ_BYTE, 4'hb, 4'hc, 1'b0, 32'h0000_0000);
    reg_is(3'h3, 32'h0000_01fe);
    run(OP_MOV_IMM, SZ_LONG, 4'h4, 4'h0, 1'b1, 32'h0000_0007);
    run(OP_UNSIGNED_DIVIDE, SZ_BYTE, 4'hb, 4'hc, 1'b0, 32'h0000_0000);
    reg_is(3'h3, 32'h0000_0648);
    $display("test muldiv done");
  endtask
  task automatic t_stack;
    run(OP_MOV_IMM, SZ_LONG, 4'h7, 4'h0, 1'b1, 32'h0000_1001);
    run(OP_PUSH, SZ_LONG, 4'h0, 4'h0, 1'b0, 32'h0000_0000);
    check(m_addr, 32'h0000_0ffc);
    check(m_wdata, 32'h1234_56ab);
    check(32'(m_we), 32'h1);
    @(posedge clk);
    mem_rdata <= 32'hcafe_f00d;
    run(OP_POP, SZ_LONG, 4'h5, 4'h0, 1'b0, 32'h0000_0000);
    check(m_addr, 32'h0000_0ffc);
    check(32'(m_we), 32'h0);
    reg_is(3'h5, 32'hcafe_f00d);
    run(OP_MOV_STORE, SZ_WORD, 4'h7, 4'h0, 1'b0, 32'h0000_0000);
    check(m_addr, 32'h0000_1000);
    check(m_wdata, 32'h0000_56ab);
    run(OP_MOV_LOAD, SZ_LONG, 4'h3, 4'h7, 1'b0, 32'h0000_0000);
    reg_is(3'h3, 32'hcafe_f00d);
    run(OP_MULTI_REGISTER_STORE, SZ_LONG, 4'h0, 4'h0, 1'b0, 32'h0000_0000, 3'h1, 3'h2);
    check(beats, 2);
    check(m_addr, 32'h0000_0ff8);
    check(m_wdata, 32'h0000_0029);
    run(OP_MULTI_REGISTER_LOAD, SZ_LONG, 4'h5, 4'h0, 1'b0, 32'h0000_0000, 3'h1, 3'h2);
    reg_is(3'h6, 32'hcafe_f00d);
    reg_is(3'h7, 32'h0000_1001);
    $display("test stack done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  // Reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    flags_load = 1'b0;
    flags_in = '0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    dbg_sel = 3'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_move();
    t_arith();
    t_muldiv();
    t_stack();
    close_out();
  end
endmodule
